// *** prs_pkg.sv ***
package prs_pkg;

    // Clock and ramp timing.
    localparam int          CLK_PERIOD_NS    = 20;
    localparam int          RAMP_STEP_NS     = 320;
    localparam int          RAMP_STEP_CYC    = (RAMP_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Register offsets on the control port.
    localparam logic [7:0]  OFS_POWER_CTRL   = 8'h02;
    localparam logic [7:0]  OFS_CHAN_PDN     = 8'h03;
    localparam logic [7:0]  OFS_RAMP_CFG     = 8'h05;
    localparam logic [7:0]  OFS_CHAN_SILENCE = 8'h1E;
    localparam logic [7:0]  OFS_EVENT_EN     = 8'h1F;
    localparam logic [7:0]  OFS_EVENT_STAT   = 8'h2A;

    // Field positions.
    localparam int          POS_SLEEP        = 0;
    localparam int          POS_RAMP_MODE    = 3;
    localparam int          POS_RAMP_SPEED   = 0;
    localparam int          POS_EN_RAMP      = 0;
    localparam int          POS_EN_LOCK      = 1;
    localparam int          POS_STAT_LOCK    = 6;

    // Values after reset.
    localparam logic        RST_SLEEP        = 1'h1;
    localparam logic [7:0]  RST_CHAN_PDN     = 8'hFF;
    localparam logic [7:0]  RST_RAMP_CFG     = 8'h00;
    localparam logic [7:0]  RST_SILENCE      = 8'h00;
    localparam logic [1:0]  RST_EVENT_EN     = 2'h0;

    // Ramp mode field codes.
    localparam logic [1:0]  RAMP_MODE_DOWN   = 2'h1;
    localparam logic [1:0]  RAMP_MODE_UP     = 2'h3;

    typedef struct packed {
        logic [1:0] mode;
        logic [1:0] charge_rate_select;
    } prs_ramp_cfg_t;

    typedef enum logic [3:0] {
        ST_CLAMP = 4'b0001,
        ST_RISE  = 4'b0010,
        ST_BIAS  = 4'b0100,
        ST_FALL  = 4'b1000
    } prs_chan_state_t;

endpackage

// *** prs_ramp_chan.sv ***
`timescale 1ns/100ps
module prs_ramp_chan
    import prs_pkg::*;
#(
    parameter int PWM_W = 8
) (
    input  wire logic               ref_clk_in,
    input  wire logic               rst_n_in,
    input  wire logic               run_in,
    input  wire logic               channel_modulator_off_in,
    input  wire logic               channel_silence_bit_in,
    input  wire prs_ramp_cfg_t      cfg_in,
    input  wire logic [PWM_W-1:0]   audio_duty_in,
    output logic                    class_d_output_out,
    output logic                    ramp_done_out
);
    localparam logic [PWM_W-1:0] HALF = PWM_W'(1) << (PWM_W - 1);
    localparam logic [7:0]       STEP = 8'(RAMP_STEP_CYC);

    prs_chan_state_t  state_q, state_d;
    logic [PWM_W-1:0] level_q, level_d, phase_q, phase_d, duty_c;
    logic [10:0]      step_q, step_d;
    logic [10:0]      step_len;
    logic             pwm_q, pwm_d, done_q, done_d, tick;

    assign class_d_output_out = pwm_q;
    assign ramp_done_out      = done_q;

    always_comb begin
        step_len = (11'(STEP) << cfg_in.charge_rate_select) - 11'h001;
        tick     = (step_q == step_len);
        state_d  = state_q;
        level_d  = level_q;
        done_d   = 1'b0;
        step_d   = (state_q == ST_RISE || state_q == ST_FALL) && !tick ? step_q + 11'h001 : 11'h000;
        unique case (state_q)
            // (RULE6) Clamp at ground.
            ST_CLAMP: begin
                level_d = '0;
                if (!channel_modulator_off_in) begin
                    // (RULE13) Half-bridge ramp-up.
                    if (cfg_in.mode == RAMP_MODE_UP) begin
                        state_d = ST_RISE;
                    end else begin
                        // (RULE17) Direct enable.
                        state_d = ST_BIAS;
                        level_d = HALF;
                    end
                end
            end
            // (RULE7) Gradual rise.
            ST_RISE: begin
                if (channel_modulator_off_in) begin
                    state_d = cfg_in.mode == RAMP_MODE_DOWN ? ST_FALL : ST_CLAMP;
                    level_d = cfg_in.mode == RAMP_MODE_DOWN ? level_q : '0;
                end else if (tick) begin
                    level_d = level_q + PWM_W'(1);
                    if (level_d == HALF) begin
                        state_d = ST_BIAS;
                        // (RULE21) Flag endpoint.
                        done_d = 1'b1;
                    end
                end
            end
            ST_BIAS: begin
                if (channel_modulator_off_in) begin
                    // (RULE20) Ramp-down armed.
                    state_d = cfg_in.mode == RAMP_MODE_DOWN ? ST_FALL : ST_CLAMP;
                    level_d = cfg_in.mode == RAMP_MODE_DOWN ? level_q : '0;
                end
            end
            // (RULE10) Gradual fall.
            ST_FALL: begin
                if (!channel_modulator_off_in) begin
                    state_d = cfg_in.mode == RAMP_MODE_UP ? ST_RISE : ST_BIAS;
                    level_d = cfg_in.mode == RAMP_MODE_UP ? level_q : HALF;
                end else if (tick) begin
                    level_d = level_q - PWM_W'(1);
                    if (level_d == '0) begin
                        state_d = ST_CLAMP;
                        done_d  = 1'b1;
                    end
                end
            end
        endcase
        // (RULE9) Mute holds the bias duty.
        duty_c  = (state_q == ST_BIAS && !channel_silence_bit_in) ? audio_duty_in : level_q;
        phase_d = phase_q + PWM_W'(1);
        pwm_d   = run_in && (phase_q < duty_c);
        if (!run_in) begin
            state_d = ST_CLAMP;
            level_d = '0;
            step_d  = '0;
            done_d  = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            state_q <= ST_CLAMP;
            level_q <= '0;
            phase_q <= '0;
            step_q  <= '0;
            pwm_q   <= 1'b0;
            done_q  <= 1'b0;
        end else begin
            state_q <= state_d;
            level_q <= level_d;
            phase_q <= phase_d;
            step_q  <= step_d;
            pwm_q   <= pwm_d;
            done_q  <= done_d;
        end
    end

    property p_clamp_low;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        state_q == ST_CLAMP |=> !pwm_q;
    endproperty
    a_clamp_low: assert property (p_clamp_low) else $error("clamped channel drove its output high"); // (RULE6)

    property p_rise_up;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        (state_q == ST_RISE && run_in && !channel_modulator_off_in) |=> level_q >= $past(level_q);
    endproperty
    a_rise_up: assert property (p_rise_up) else $error("rising ramp level went down"); // (RULE7)

    property p_fall_down;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        (state_q == ST_FALL && channel_modulator_off_in) |=> level_q <= $past(level_q);
    endproperty
    a_fall_down: assert property (p_fall_down) else $error("falling ramp level went up"); // (RULE10)

    property p_mute_bias;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        (state_q == ST_BIAS && channel_silence_bit_in) |-> duty_c == HALF;
    endproperty
    a_mute_bias: assert property (p_mute_bias) else $error("muted channel not at half duty"); // (RULE9)

    property p_done_end;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        done_q |-> (level_q == HALF && state_q == ST_BIAS) || (level_q == '0 && state_q == ST_CLAMP);
    endproperty
    a_done_end: assert property (p_done_end) else $error("ramp done away from an end point"); // (RULE21)
endmodule

// *** prs_power_sequencer.sv ***
`timescale 1ns/100ps
// Overview of operation
// (RULE1) Reset low puts everything in low power with all registers at defaults.
// (RULE2) After reset the port works; operation starts when the sleep bit is cleared.
// (RULE3) All PWM outputs are driven low while reset is asserted.
// (RULE4) Clock output is crystal rate with mute low, half rate with mute high.
// (RULE5) Mute level at reset release selects the clock output divider.
// (RULE6) Configured for ramp-up, outputs stay clamped to ground until enabled.
// (RULE7) Enabling a channel with ramp-up raises duty from ground to 50% gradually.
// (RULE8) Each channel ramps up and down independently.
// (RULE9) A muted channel outputs no audio and holds about 50% duty.
// (RULE10) Powering down with ramp-down lowers the offset gradually to ground.
// (RULE11) Host mutes a channel before powering it down.
// (RULE12) Host loads setup and mutes all channels while the sleep bit is one.
// (RULE13) Host sets ramp mode 11, speed and zero minimum pulse for half-bridge.
// (RULE14) Host writes ramp mode 01 once ramp-up finishes.
// (RULE15) Leaving sleep starts rate converter locking; lock may raise the interrupt.
// (RULE16) Ramp completion may raise the host interrupt when enabled.
// (RULE17) Host may skip ramps for full-bridge stages and enable directly.
// (RULE18) Host enables rejection feedback after ramp-up, then unmutes.
// (RULE19) Host enables power stages only after lock, before modulators.
// (RULE20) Host sets ramp mode 01 and speed before powering down half-bridge.
// (RULE21) Ramp counter steps per speed interval and flags completion at its end.
module prs_power_sequencer
    import prs_pkg::*;
#(
    parameter int NCH   = 6,
    parameter int PWM_W = 8
) (
    input  wire logic                      ref_clk_in,
    input  wire logic                      rst_n_in,
    input  wire logic                      mute_pin_in,
    input  wire logic                      reg_wr_in,
    input  wire logic                      reg_rd_in,
    input  wire logic [7:0]                reg_addr_in,
    input  wire logic [7:0]                reg_wdata_in,
    input  wire logic                      rate_converter_locked_in,
    input  wire logic [NCH-1:0][PWM_W-1:0] audio_duty_in,
    output logic      [7:0]                reg_rdata_out,
    output logic      [NCH-1:0]            class_d_output_out,
    output logic                           divided_clock_out,
    output logic                           rate_converter_run_out,
    output logic                           host_int_out
);
    if (NCH < 1 || NCH > 6) begin : g_bad_nch
        $error("NCH must be 1 to 6");
    end
    if (PWM_W < 2 || PWM_W > 12) begin : g_bad_pwm
        $error("PWM_W must be 2 to 12");
    end

    logic            sleep_q, sleep_d;
    logic [NCH-1:0]  chan_off_q, chan_off_d, silence_q, silence_d;
    logic [NCH-1:0]  ramp_stat_q, ramp_stat_d, done_c, pwm_c;
    prs_ramp_cfg_t   cfg_q, cfg_d;
    logic [1:0]      ev_en_q, ev_en_d;
    logic            lock_stat_q, lock_stat_d, lock_prev_q, lock_prev_d;
    logic [7:0]      rdata_q, rdata_d;
    logic            div2_q, div2_d, half_q, half_d, int_q, int_d;
    logic            run_q, run_d;
    logic            wr_pwr, wr_pdn, wr_cfg, wr_sil, wr_en;

    assign reg_rdata_out          = rdata_q;
    assign class_d_output_out     = pwm_c;
    assign rate_converter_run_out = run_q;
    assign host_int_out           = int_q;
    // (RULE4) Full rate passes the crystal clock; a flop cannot toggle at its own clock rate.
    assign divided_clock_out      = div2_q ? half_q : ref_clk_in;

    // (RULE8) One independent ramp engine per channel.
    for (genvar ch = 0; ch < NCH; ch++) begin : g_chan
        prs_ramp_chan #(
            .PWM_W(PWM_W)
        ) u_chan (
            .ref_clk_in               (ref_clk_in),
            .rst_n_in                 (rst_n_in),
            .run_in                   (!sleep_q),
            .channel_modulator_off_in (chan_off_q[ch]),
            .channel_silence_bit_in   (silence_q[ch]),
            .cfg_in                   (cfg_q),
            .audio_duty_in            (audio_duty_in[ch]),
            .class_d_output_out       (pwm_c[ch]),
            .ramp_done_out            (done_c[ch])
        );
    end

    always_comb begin
        wr_pwr = reg_wr_in && reg_addr_in == OFS_POWER_CTRL;
        wr_pdn = reg_wr_in && reg_addr_in == OFS_CHAN_PDN;
        wr_cfg = reg_wr_in && reg_addr_in == OFS_RAMP_CFG;
        wr_sil = reg_wr_in && reg_addr_in == OFS_CHAN_SILENCE;
        wr_en  = reg_wr_in && reg_addr_in == OFS_EVENT_EN;
        // (RULE2) Leaving low power only by clearing the sleep bit.
        sleep_d    = wr_pwr ? reg_wdata_in[POS_SLEEP] : sleep_q;
        // The run level is its own flop so that the pin needs no inverter after the sleep flop.
        run_d      = !sleep_d;
        chan_off_d = wr_pdn ? reg_wdata_in[NCH-1:0] : chan_off_q;
        cfg_d      = cfg_q;
        if (wr_cfg) begin
            cfg_d.mode               = reg_wdata_in[POS_RAMP_MODE +: 2];
            cfg_d.charge_rate_select = reg_wdata_in[POS_RAMP_SPEED +: 2];
        end
        silence_d = wr_sil ? reg_wdata_in[NCH-1:0] : silence_q;
        ev_en_d   = wr_en ? reg_wdata_in[1:0] : ev_en_q;
        // Status clears on read; a completion in the same cycle still lands.
        ramp_stat_d = (reg_rd_in && reg_addr_in == OFS_EVENT_STAT ? '0 : ramp_stat_q) | done_c;
        lock_prev_d = rate_converter_locked_in && !sleep_q;
        // (RULE15) Lock completion is caught once the converter runs.
        lock_stat_d = (reg_rd_in && reg_addr_in == OFS_EVENT_STAT ? 1'b0 : lock_stat_q)
                    | (lock_prev_d && !lock_prev_q);
        // (RULE16) Enabled events drive the host interrupt.
        int_d = (ev_en_q[POS_EN_RAMP] && |ramp_stat_d) || (ev_en_q[POS_EN_LOCK] && lock_stat_d);
        rdata_d = rdata_q;
        if (reg_rd_in) begin
            rdata_d = 8'h00;
            unique case (reg_addr_in)
                OFS_POWER_CTRL:   rdata_d[POS_SLEEP] = sleep_q;
                OFS_CHAN_PDN:     rdata_d[NCH-1:0] = chan_off_q;
                OFS_RAMP_CFG:     rdata_d = {3'h0, cfg_q.mode, 1'b0, cfg_q.charge_rate_select};
                OFS_CHAN_SILENCE: rdata_d[NCH-1:0] = silence_q;
                OFS_EVENT_EN:     rdata_d[1:0] = ev_en_q;
                OFS_EVENT_STAT: begin
                    rdata_d[NCH-1:0]      = ramp_stat_q;
                    rdata_d[POS_STAT_LOCK] = lock_stat_q;
                end
                default:          rdata_d = 8'h00;
            endcase
        end
        // (RULE5) The mute pin is followed during reset and frozen at release.
        div2_d = div2_q;
        half_d = div2_q ? !half_q : 1'b0;
    end

    always_ff @(posedge ref_clk_in) begin
        // (RULE1) Everything back to defaults while reset is low.
        if (!rst_n_in) begin
            sleep_q     <= RST_SLEEP;
            run_q       <= !RST_SLEEP;
            chan_off_q  <= RST_CHAN_PDN[NCH-1:0];
            cfg_q       <= prs_ramp_cfg_t'({RST_RAMP_CFG[POS_RAMP_MODE +: 2], RST_RAMP_CFG[POS_RAMP_SPEED +: 2]});
            silence_q   <= RST_SILENCE[NCH-1:0];
            ev_en_q     <= RST_EVENT_EN;
            ramp_stat_q <= '0;
            lock_stat_q <= 1'b0;
            lock_prev_q <= 1'b0;
            rdata_q     <= 8'h00;
            int_q       <= 1'b0;
            half_q      <= 1'b0;
        end else begin
            sleep_q     <= sleep_d;
            run_q       <= run_d;
            chan_off_q  <= chan_off_d;
            cfg_q       <= cfg_d;
            silence_q   <= silence_d;
            ev_en_q     <= ev_en_d;
            ramp_stat_q <= ramp_stat_d;
            lock_stat_q <= lock_stat_d;
            lock_prev_q <= lock_prev_d;
            rdata_q     <= rdata_d;
            int_q       <= int_d;
            half_q      <= half_d;
        end
    end

    // Clocked capture of the strap level; not an asynchronous load.
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            div2_q <= mute_pin_in;
        end else begin
            div2_q <= div2_d;
        end
    end

    property p_reset_low;
        @(posedge ref_clk_in) !rst_n_in |=> pwm_c == '0;
    endproperty
    a_reset_low: assert property (p_reset_low) else $error("PWM output high during reset"); // (RULE3)

    property p_reset_sleep;
        @(posedge ref_clk_in) !rst_n_in |=> sleep_q && chan_off_q == '1 && ev_en_q == '0 && silence_q == '0;
    endproperty
    a_reset_sleep: assert property (p_reset_sleep) else $error("reset did not restore defaults"); // (RULE1)

    property p_stay_asleep;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        (sleep_q && !(wr_pwr && !reg_wdata_in[POS_SLEEP])) |=> sleep_q;
    endproperty
    a_stay_asleep: assert property (p_stay_asleep) else $error("left sleep without a write"); // (RULE2)

    property p_strap;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        $rose(rst_n_in) |-> div2_q == $past(mute_pin_in) ##1 div2_q == $past(div2_q);
    endproperty
    a_strap: assert property (p_strap) else $error("divider strap not held from release"); // (RULE5)

    property p_half_rate;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        (div2_q && $past(rst_n_in)) |-> half_q != $past(half_q);
    endproperty
    a_half_rate: assert property (p_half_rate) else $error("half rate clock did not toggle"); // (RULE4)

    property p_ramp_int;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        (|done_c && ev_en_q[POS_EN_RAMP] && !wr_en) |=> host_int_out && ramp_stat_q != '0;
    endproperty
    a_ramp_int: assert property (p_ramp_int) else $error("ramp completion missed the interrupt"); // (RULE16)

    property p_lock_int;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        (lock_stat_q && ev_en_q[POS_EN_LOCK] && !reg_rd_in && !wr_en) |=> host_int_out;
    endproperty
    a_lock_int: assert property (p_lock_int) else $error("lock completion missed the interrupt"); // (RULE15)

    property p_sleep_clamp;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        sleep_q [*2] |-> pwm_c == '0;
    endproperty
    a_sleep_clamp: assert property (p_sleep_clamp) else $error("output active in low power"); // (RULE6)
endmodule

// *** prs_lock_model.sv ***
`timescale 1ns/100ps
module prs_lock_model #(
    parameter int LOCK_CYC = 50
) (
    input  wire logic ref_clk_in,
    input  wire logic rst_n_in,
    input  wire logic run_in,
    output logic      locked_out
);
    int cnt;
    // lock after clocks start.
    // Lock drops at once when clocks stop, so a later wake-up must lock again.
    always @(posedge ref_clk_in) begin
        if (rst_n_in !== 1'b1 || run_in !== 1'b1) begin
            cnt        <= 0;
            locked_out <= 1'b0;
        end else if (cnt < LOCK_CYC) begin
            cnt <= cnt + 1;
        end else begin
            locked_out <= 1'b1;
        end
    end
endmodule

// *** tb.sv ***
`timescale 1ns/100ps
module tb;
    import prs_pkg::*;
    localparam int             NCH = 6;
    localparam int             PWM_W = 8;
    logic                      ref_clk_in, rst_n_in, mute_pin_in, reg_wr_in, reg_rd_in, locked;
    logic [7:0]                reg_addr_in, reg_wdata_in, reg_rdata_out;
    logic [NCH-1:0][PWM_W-1:0] audio_duty_in;
    logic [NCH-1:0]            class_d_output_out;
    logic                      divided_clock_out, rate_converter_run_out, host_int_out;
    int                        fails, tests_run, dclk_edges, n, c;

    prs_power_sequencer #(.NCH(NCH), .PWM_W(PWM_W)) prs_power_sequencer_i (
        .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .mute_pin_in(mute_pin_in),
        .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .rate_converter_locked_in(locked),
        .audio_duty_in(audio_duty_in), .reg_rdata_out(reg_rdata_out),
        .class_d_output_out(class_d_output_out), .divided_clock_out(divided_clock_out),
        .rate_converter_run_out(rate_converter_run_out), .host_int_out(host_int_out));
    prs_lock_model prs_lock_model_i (
        .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .run_in(rate_converter_run_out),
        .locked_out(locked));

    initial begin
        ref_clk_in = 1'b0;
        forever #(CLK_PERIOD_NS / 2) ref_clk_in = ~ref_clk_in;
    end
    always @(posedge divided_clock_out) dclk_edges++;

    task automatic stop_test;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            $display("FAIL %s expected %0h seen %0h", name, exp, got);
            fails++;
        end
    endtask
    task automatic chk_in(input string name, input int lo, input int hi, input int got);
        tests_run++;
        if (got < lo || got > hi) begin
            $display("FAIL %s expected %0d..%0d seen %0d", name, lo, hi, got);
            fails++;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_in);
        reg_wr_in    <= 1'b1;
        reg_addr_in  <= a;
        reg_wdata_in <= d;
        @(posedge ref_clk_in);
        reg_wr_in    <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string name);
        @(posedge ref_clk_in);
        reg_rd_in   <= 1'b1;
        reg_addr_in <= a;
        @(posedge ref_clk_in);
        reg_rd_in   <= 1'b0;
        @(negedge ref_clk_in);
        chk(name, exp, reg_rdata_out);
    endtask
    task automatic wait_cyc(input int k);
        repeat (k) @(negedge ref_clk_in);
    endtask
    task automatic high_count(input int ch, input int k, output int cnt);
        cnt = 0;
        repeat (k) begin
            @(negedge ref_clk_in);
            if (class_d_output_out[ch] === 1'b1)
                cnt++;
        end
    endtask
    task automatic wait_int(input int max, inout int cnt);
        while (host_int_out !== 1'b1 && cnt < max) begin
            @(negedge ref_clk_in);
            cnt++;
        end
    endtask
    task automatic clock_rate(input int exp);
        @(negedge ref_clk_in);
        dclk_edges = 0;
        wait_cyc(40);
        chk("clock out edges", exp, dclk_edges);
    endtask

    task automatic t_defaults;
        rd(OFS_POWER_CTRL, 8'h01, "sleep reset");
        rd(OFS_CHAN_PDN, 8'h3F, "chan off reset");
        rd(OFS_RAMP_CFG, 8'h00, "ramp cfg reset");
        rd(OFS_CHAN_SILENCE, 8'h00, "silence reset");
        rd(OFS_EVENT_EN, 8'h00, "event en reset");
        rd(OFS_EVENT_STAT, 8'h00, "status reset");
        rd(8'h40, 8'h00, "unmapped read");
        chk("run after reset", 1'b0, rate_converter_run_out);
    endtask
    task automatic t_power_up;
        wr(OFS_CHAN_SILENCE, 8'h3F);
        wr(OFS_RAMP_CFG, 8'h18);
        wr(OFS_EVENT_EN, 8'h03);
        wr(OFS_POWER_CTRL, 8'h00);
        @(negedge ref_clk_in);
        chk("run after wake", 1'b1, rate_converter_run_out);
        high_count(0, 256, c);
        chk("clamped duty", 0, c);
        chk("lock event", 1'b1, host_int_out);
        rd(OFS_EVENT_STAT, 8'h40, "lock status");
        wait_cyc(2);
        chk("event cleared", 1'b0, host_int_out);
    endtask
    task automatic t_ramp(input logic [7:0] mode, input logic [7:0] off, input int end_duty);
        wr(OFS_RAMP_CFG, mode);
        wr(OFS_CHAN_PDN, off);
        n = 0;
        wait_cyc(900);
        high_count(0, 256, c);
        chk_in("mid ramp duty", 16, 112, c);
        n = 1156;
        wait_int(2300, n);
        chk_in("ramp length", 2040, 2100, n);
        rd(OFS_EVENT_STAT, 8'h01, "ramp status");
        high_count(0, 256, c);
        chk("end duty", end_duty, c);
        high_count(1, 256, c);
        chk("other channel", 0, c);
    endtask
    task automatic t_unmute;
        wr(OFS_CHAN_SILENCE, 8'h3E);
        wait_cyc(2);
        high_count(0, 256, c);
        chk("audio duty", 64, c);
        wr(OFS_CHAN_SILENCE, 8'h3F);
        wait_cyc(2);
        high_count(0, 256, c);
        chk("muted duty", 128, c);
    endtask
    task automatic t_direct_reset;
        wr(OFS_RAMP_CFG, 8'h00);
        wr(OFS_CHAN_PDN, 8'h3B);
        wait_cyc(2);
        high_count(2, 256, c);
        chk("direct bias", 128, c);
        @(posedge ref_clk_in);
        rst_n_in    <= 1'b0;
        mute_pin_in <= 1'b1;
        @(posedge ref_clk_in);
        @(negedge ref_clk_in);
        chk("outputs in reset", 6'h00, class_d_output_out);
        @(posedge ref_clk_in);
        rst_n_in <= 1'b1;
        @(posedge ref_clk_in);
        mute_pin_in <= 1'b0;
        clock_rate(20);
        t_defaults();
    endtask
    task automatic t_sleep;
        wr(OFS_CHAN_SILENCE, 8'h3F);
        wr(OFS_CHAN_PDN, 8'h3E);
        high_count(0, 256, c);
        chk("asleep duty", 0, c);
        wr(OFS_POWER_CTRL, 8'h00);
        wait_cyc(2);
        high_count(0, 256, c);
        chk("awake duty", 128, c);
        wr(OFS_POWER_CTRL, 8'h01);
        wait_cyc(2);
        chk("run in sleep", 1'b0, rate_converter_run_out);
        high_count(0, 256, c);
        chk("sleep duty", 0, c);
    endtask
    task automatic t_speed;
        wr(OFS_RAMP_CFG, 8'h1B);
        wr(OFS_POWER_CTRL, 8'h00);
        wait_cyc(2000);
        high_count(0, 256, c);
        chk_in("slow ramp duty", 12, 20, c);
    endtask

    initial begin
        rst_n_in      = 1'b0;
        mute_pin_in   = 1'b0;
        reg_wr_in     = 1'b0;
        reg_rd_in     = 1'b0;
        reg_addr_in   = 8'h00;
        reg_wdata_in  = 8'h00;
        audio_duty_in = {NCH{8'h40}};
        fails         = 0;
        tests_run     = 0;
        @(posedge ref_clk_in);
        @(negedge ref_clk_in);
        chk("outputs in reset", 6'h00, class_d_output_out);
        @(posedge ref_clk_in);
        rst_n_in <= 1'b1;
        clock_rate(40);
        t_defaults();
        t_power_up();
        t_ramp(8'h18, 8'h3E, 128);
        t_unmute();
        t_ramp(8'h08, 8'h3F, 0);
        t_direct_reset();
        t_sleep();
        t_speed();
        stop_test();
    end
    initial begin
        #(40000 * CLK_PERIOD_NS);
        fails++;
        stop_test();
    end
endmodule
